// *** design/hfs_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module hfs_sequencer
  import hfs_pkg::*;
#(
  parameter int unsigned COOL_CYCLES = COOL_CYC,
  parameter int unsigned SS_CYCLES = SS_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire hfs_pkg::hfs_faults_t faults,
  input wire hfs_pkg::hfs_gate_t pwm_req,
  input wire logic supply_undervoltage_lockout,
  input wire logic shutdown,
  input wire logic [hfs_pkg::REF_W-1:0] bandgap_ref,
  input wire logic [hfs_pkg::REF_W-1:0] ext_ss_level,
  output hfs_pkg::hfs_gate_t gate_out,
  output logic ext_ss_discharge,
  output logic [hfs_pkg::REF_W-1:0] amp_ref,
  output logic ext_ss_active,
  output logic irq
);
  import hfs_pkg::*;

  localparam int CW = $clog2(COOL_CYCLES + SS_CYCLES + 1);
  localparam int UW = $clog2(UV_CYC + 1);
  localparam int BW = $clog2(BLANK_CYC + 1);
  localparam logic [CW-1:0] COOL_LAST = CW'(COOL_CYCLES - 1);
  localparam logic [CW-1:0] SS_LAST = CW'(SS_CYCLES - 1);
  localparam logic [UW-1:0] UV_LAST = UW'(UV_CYC - 1);
  localparam logic [BW-1:0] BLANK_N = BW'(BLANK_CYC);

  hfs_state_t st_q, st_d;
  logic [CW-1:0] tmr_q, tmr_d;
  logic [4:0] ls_cnt_q, ls_cnt_d;
  logic [5:0] clean_q, clean_d;
  logic [UW-1:0] uv_q, uv_d;
  logic [BW-1:0] blank_q, blank_d;
  logic [REF_W-1:0] iss_q, iss_d;
  logic [EV_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic [31:0] prdata_d;
  logic ls_trip, hs_trip, uv_trip, hiccup, lockout, ss_busy;

  assign lockout = supply_undervoltage_lockout | shutdown;
  assign ext_ss_discharge = lockout;
  // External ramp counts as soft-start until it passes the bandgap
  assign ext_ss_active = ext_ss_level < bandgap_ref;
  assign ss_busy = (st_q == HFS_SS) | ext_ss_active;

  // Low-side fault counter and clean-cycle counter
  always_comb begin
    ls_cnt_d = ls_cnt_q;
    clean_d = clean_q;
    ls_trip = 1'b0;
    if (st_q == HFS_COOL) begin
      ls_cnt_d = '0;
      clean_d = '0;
    end else if (faults.off_start) begin
      if (faults.ls_over) begin
        clean_d = '0;
        if (ls_cnt_q == 5'(LS_TRIP - 1)) begin
          ls_trip = 1'b1;
          ls_cnt_d = '0;
        end else begin
          ls_cnt_d = ls_cnt_q + 5'd1;
        end
      end else if (clean_q == 6'(LS_CLEAR - 1)) begin
        ls_cnt_d = '0;
        clean_d = '0;
      end else begin
        clean_d = clean_q + 6'd1;
      end
    end
  end

  // High-side blanking after each turn-on
  always_comb begin
    blank_d = blank_q;
    if (faults.hs_on && !pwm_req.high_side_drive) begin
      blank_d = BLANK_N;
    end else if (blank_q != '0) begin
      blank_d = blank_q - BW'(1);
    end
    hs_trip = (st_q != HFS_COOL) && faults.hs_over
      && (blank_q == '0) && gate_out.high_side_drive;
  end

  // Under-voltage glitch filter, armed only in steady state
  always_comb begin
    uv_d = '0;
    uv_trip = 1'b0;
    if (st_q == HFS_RUN && !ss_busy && faults.uv_low) begin
      if (uv_q == UV_LAST) begin
        uv_trip = 1'b1;
      end else begin
        uv_d = uv_q + UW'(1);
      end
    end
  end

  assign hiccup = ls_trip | hs_trip | uv_trip;

  // Hiccup sequencer
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    iss_d = iss_q;
    case (st_q)
      HFS_RUN: begin
        iss_d = REF_FULL;
        if (hiccup) begin
          st_d = HFS_COOL;
          tmr_d = '0;
          iss_d = '0;
        end
      end
      HFS_COOL: begin
        iss_d = '0;
        if (tmr_q == COOL_LAST) begin
          st_d = HFS_SS;
          tmr_d = '0;
        end else begin
          tmr_d = tmr_q + CW'(1);
        end
      end
      HFS_SS: begin
        if (hiccup) begin
          st_d = HFS_COOL;
          tmr_d = '0;
          iss_d = '0;
        end else if (tmr_q == SS_LAST) begin
          st_d = HFS_RUN;
          iss_d = REF_FULL;
        end else begin
          tmr_d = tmr_q + CW'(1);
          iss_d = REF_W'((32'(REF_FULL) * 32'(tmr_q)) / SS_CYCLES);
        end
      end
      default: st_d = HFS_RUN;
    endcase
  end

  always_comb begin
    amp_ref = bandgap_ref;
    if (ext_ss_level < amp_ref) amp_ref = ext_ss_level;
    if (iss_q < amp_ref) amp_ref = iss_q;
  end

  always_comb begin
    gate_out = pwm_req;
    if (st_q == HFS_COOL || lockout) begin
      gate_out = '0;
    end
  end

  // APB slave: zero wait states, unmapped reads as zero with error
  assign pready = 1'b1;
  always_comb begin
    logic acc;
    logic [EV_W-1:0] ev;
    acc = psel & penable;
    ev = '0;
    ev[EV_LS] = ls_trip;
    ev[EV_HS] = hs_trip;
    ev[EV_UV] = uv_trip;
    ev[EV_DONE] = (st_q == HFS_SS) && (st_d == HFS_RUN);
    stat_d = stat_q;
    mask_d = mask_q;
    prdata_d = prdata;
    pslverr = 1'b0;
    if (acc && pwrite && paddr == ADDR_STATUS) begin
      stat_d = stat_q & ~pwdata[EV_W-1:0];
    end else if (acc && pwrite && paddr == ADDR_MASK) begin
      mask_d = pwdata[EV_W-1:0];
    end
    // Set beats clear in the same cycle
    stat_d = stat_d | ev;
    if (acc && paddr != ADDR_STATUS && paddr != ADDR_MASK
        && paddr != ADDR_STATE && paddr != ADDR_LSCNT) begin
      pslverr = 1'b1;
    end
    if (psel && !penable && !pwrite) begin
      if (paddr == ADDR_STATUS) begin
        prdata_d = {28'h0, stat_q};
      end else if (paddr == ADDR_MASK) begin
        prdata_d = {28'h0, mask_q};
      end else if (paddr == ADDR_STATE) begin
        prdata_d = {30'h0, st_q};
      end else if (paddr == ADDR_LSCNT) begin
        prdata_d = {27'h0, ls_cnt_q};
      end else begin
        prdata_d = 32'h0;
      end
    end
  end

  assign irq = |(stat_q & mask_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= HFS_SS;
      tmr_q <= '0;
      ls_cnt_q <= '0;
      clean_q <= '0;
      uv_q <= '0;
      blank_q <= '0;
      iss_q <= '0;
      stat_q <= '0;
      mask_q <= '0;
      prdata <= 32'h0;
    end else if (lockout) begin
      // Lockout restarts the whole start-up sequence
      st_q <= HFS_SS;
      tmr_q <= '0;
      ls_cnt_q <= '0;
      clean_q <= '0;
      uv_q <= '0;
      blank_q <= '0;
      iss_q <= '0;
      stat_q <= stat_d;
      mask_q <= mask_d;
      prdata <= prdata_d;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      ls_cnt_q <= ls_cnt_d;
      clean_q <= clean_d;
      uv_q <= uv_d;
      blank_q <= blank_d;
      iss_q <= iss_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      prdata <= prdata_d;
    end
  end

  a_cool_gates_off: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == HFS_COOL |-> gate_out == '0)
    else $error("gate drive on during cool-down");
  a_hiccup_entry: assert property (@(posedge pclk) disable iff (!presetn)
    hiccup && !lockout |=> st_q == HFS_COOL && tmr_q == '0 && iss_q == '0)
    else $error("hiccup entry not taken");
  a_cool_to_ss: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == HFS_COOL && tmr_q == COOL_LAST && !lockout |=> st_q == HFS_SS)
    else $error("cool-down end missed");
  a_uv_masked_ss: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == HFS_SS |-> !uv_trip)
    else $error("under-voltage acted in soft-start");
  a_uv_filter: assert property (@(posedge pclk) disable iff (!presetn)
    uv_trip |-> $past(faults.uv_low) && uv_q == UV_LAST)
    else $error("under-voltage trip too early");
  a_ls_count: assert property (@(posedge pclk) disable iff (!presetn)
    ls_trip |-> ls_cnt_q == 5'd14 && faults.off_start)
    else $error("low-side trip count wrong");
  a_ref_lowest: assert property (@(posedge pclk) disable iff (!presetn)
    amp_ref <= bandgap_ref && amp_ref <= ext_ss_level && amp_ref <= iss_q)
    else $error("reference not lowest");
  a_hs_blank: assert property (@(posedge pclk) disable iff (!presetn)
    blank_q != '0 |-> !hs_trip)
    else $error("high-side trip in blanking");
  a_ext_ss_keep: assert property (@(posedge pclk) disable iff (!presetn)
    hiccup && !lockout |-> !ext_ss_discharge)
    else $error("external ramp discharged on hiccup");
  a_run_follows: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == HFS_RUN && !lockout |-> gate_out == pwm_req)
    else $error("gate drive blocked in normal run");
  // Lockout restarts the ramp but keeps the interrupt registers
  a_lockout_restart: assert property (@(posedge pclk) disable iff (!presetn)
    lockout |=> st_q == HFS_SS && iss_q == '0)
    else $error("lockout did not restart soft-start");
  a_ls_clean_clear: assert property (@(posedge pclk) disable iff (!presetn)
    st_q != HFS_COOL && !lockout && faults.off_start && !faults.ls_over
    && clean_q == 6'(LS_CLEAR - 1) |=> ls_cnt_q == '0)
    else $error("low-side count not cleared");
  c_lockout: cover property (@(posedge pclk) disable iff (!presetn) lockout);
  c_hiccup_ls: cover property (@(posedge pclk) disable iff (!presetn) ls_trip);
  c_hiccup_hs: cover property (@(posedge pclk) disable iff (!presetn) hs_trip);
  c_hiccup_uv: cover property (@(posedge pclk) disable iff (!presetn) uv_trip);
  c_recover: cover property (@(posedge pclk) disable iff (!presetn)
    st_q == HFS_SS ##1 st_q == HFS_RUN);
endmodule : hfs_sequencer
`default_nettype wire

// *** design/hfs_pkg.sv ***
package hfs_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned COOL_US = 5500;
  localparam int unsigned SS_US = 3600;
  localparam int unsigned UV_NS = 7000;
  localparam int unsigned BLANK_NS = 200;
  localparam int unsigned COOL_CYC = (CLK_HZ / 1000000) * COOL_US;
  localparam int unsigned SS_CYC = (CLK_HZ / 1000000) * SS_US;
  localparam int unsigned UV_CYC = (UV_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned BLANK_CYC = (BLANK_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned LS_TRIP = 15;
  localparam int unsigned LS_CLEAR = 32;
  localparam int unsigned REF_W = 12;
  localparam logic [REF_W-1:0] REF_FULL = 12'hfff;
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_MASK = 12'h004;
  localparam logic [11:0] ADDR_STATE = 12'h008;
  localparam logic [11:0] ADDR_LSCNT = 12'h00c;
  localparam int unsigned EV_LS = 0;
  localparam int unsigned EV_HS = 1;
  localparam int unsigned EV_UV = 2;
  localparam int unsigned EV_DONE = 3;
  localparam int unsigned EV_W = 4;

  typedef enum logic [1:0] {
    HFS_RUN = 2'b00,
    HFS_COOL = 2'b01,
    HFS_SS = 2'b10
  } hfs_state_t;

  typedef struct packed {
    logic off_start;
    logic ls_over;
    logic hs_on;
    logic hs_over;
    logic uv_low;
  } hfs_faults_t;

  typedef struct packed {
    logic high_side_drive;
    logic low_side_drive;
  } hfs_gate_t;
endpackage : hfs_pkg

// *** verif/hfs_plant.sv ***
`timescale 1ns/1ps
`default_nettype none
module hfs_plant
  import hfs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire hfs_pkg::hfs_gate_t gate_out,
  input wire logic ls_f,
  input wire logic uv_f,
  input wire logic [1:0] hs_mode,
  output hfs_pkg::hfs_faults_t faults,
  output hfs_pkg::hfs_gate_t pwm_req
);
  logic [4:0] ph_q;
  logic hs_win;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph_q <= 5'h00;
    else ph_q <= ph_q + 5'h01;
  end
  // Period of 32 cycles so a late high-side window clears the blanking
  assign pwm_req.high_side_drive = ph_q < 5'h14;
  assign pwm_req.low_side_drive = ph_q >= 5'h14;
  assign faults.off_start = ph_q == 5'h14;
  assign faults.ls_over = ls_f;
  assign faults.hs_on = ph_q == 5'h1f;
  // Mode 1 trips only inside the blanking span, mode 2 only after it
  assign hs_win = (hs_mode == 2'h1) ? (ph_q < 5'h06) : (ph_q >= 5'h0c);
  // The drop only exists while the high-side switch really conducts
  assign faults.hs_over = gate_out.high_side_drive && hs_mode != 2'h0 && hs_win;
  assign faults.uv_low = uv_f;
endmodule : hfs_plant
`default_nettype wire

// *** verif/hiccup_fault_sequencer_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t %h %h", $time, g, e); end end
module hiccup_fault_sequencer_test;
  import hfs_pkg::*;
  localparam int CC = 60;
  localparam int SC = 400;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic lock = 0, shut = 0, ls_f = 0, uv_f = 1, slv, pready, pslverr;
  logic dis, act, irq;
  logic [1:0] hs_mode = 2'h0;
  logic [11:0] paddr = 12'h000, bg = 12'h800, ext = 12'h900, amp;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h3;
  hfs_faults_t faults;
  hfs_gate_t pwm_req, gate_out;
  int err_total = 0, cmp_count = 0, n;
  hfs_sequencer #(.COOL_CYCLES(CC), .SS_CYCLES(SC)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .faults(faults), .pwm_req(pwm_req),
    .supply_undervoltage_lockout(lock), .shutdown(shut), .bandgap_ref(bg),
    .ext_ss_level(ext), .gate_out(gate_out), .ext_ss_discharge(dis),
    .amp_ref(amp), .ext_ss_active(act), .irq(irq));
  hfs_plant plant (.pclk(pclk), .presetn(presetn), .gate_out(gate_out),
    .ls_f(ls_f), .uv_f(uv_f), .hs_mode(hs_mode), .faults(faults),
    .pwm_req(pwm_req));
  initial forever #10 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic int lo3(input int a, input int b, input int c);
    return (a < b) ? ((a < c) ? a : c) : ((b < c) ? b : c);
  endfunction : lo3
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(pready, 1'b1)
  endtask : rchk
  // Holds the valley comparator level across k sampled off-time starts
  task automatic ls_run(input int k, input logic v);
    ls_f <= v;
    repeat (k) begin
      @(posedge pclk);
      while (faults.off_start !== 1'b1) @(posedge pclk);
    end
  endtask : ls_run
  task automatic hiccup(input int lim, input logic [31:0] st, input logic ei);
    seed = xs(seed);
    bg <= seed[11:0] | 12'h100;
    seed = xs(seed);
    ext <= seed[23:12] | 12'h100;
    n = 0;
    while (gate_out !== 2'b00 && n < lim) begin
      n++;
      @(posedge pclk);
    end
    `CHK(n < lim, 1'b1)
    `CHK(dis, 1'b0)
    n = 0;
    while (gate_out === 2'b00 && n < CC + 9) begin
      n++;
      @(posedge pclk);
    end
    `CHK(n, CC)
    `CHK(amp < 12'h020, 1'b1)
    ls_f <= 1'b0;
    uv_f <= 1'b0;
    hs_mode <= 2'h0;
    rchk(ADDR_STATUS, st);
    `CHK(irq, ei)
    apb(1'b1, ADDR_STATUS, st);
    `CHK(irq, 1'b0)
    cyc(SC);
    rchk(ADDR_STATE, 32'h0);
    `CHK(amp, 12'(lo3(bg, ext, REF_FULL)))
    `CHK(act, ext < bg)
    rchk(ADDR_STATUS, 32'h8);
    apb(1'b1, ADDR_STATUS, 32'h8);
  endtask : hiccup
  task automatic stop_test;
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial begin
    cyc(20000);
    err_total++;
    stop_test;
  end
  initial begin
    cyc(5);
    presetn <= 1'b1;
    apb(1'b1, ADDR_MASK, 32'hf);
    cyc(SC - 300);
    rchk(ADDR_STATE, 32'h2);
    cyc(300);
    rchk(ADDR_STATE, 32'h0);
    cyc(330);
    rchk(ADDR_STATE, 32'h0);
    hiccup(20, 32'hc, 1'b1);
    ls_run(14, 1'b1);
    ls_run(32, 1'b0);
    rchk(ADDR_LSCNT, 32'h0);
    ls_run(14, 1'b1);
    rchk(ADDR_LSCNT, 32'he);
    ls_run(31, 1'b0);
    rchk(ADDR_LSCNT, 32'he);
    ls_run(1, 1'b1);
    hiccup(3, 32'h1, 1'b1);
    apb(1'b1, ADDR_MASK, 32'hd);
    hs_mode <= 2'h1;
    cyc(160);
    rchk(ADDR_STATE, 32'h0);
    hs_mode <= 2'h2;
    hiccup(40, 32'h2, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    `CHK({slv, rd}, 33'h100000000)
    for (int i = 0; i < 2; i++) begin
      {lock, shut} <= 2'b10 >> i;
      cyc(3);
      `CHK(dis, 1'b1)
      {lock, shut} <= 2'b00;
      cyc(SC + 5);
      rchk(ADDR_STATE, 32'h0);
    end
    stop_test;
  end
endmodule : hiccup_fault_sequencer_test
`default_nettype wire
